// *** ims_pkg.sv ***
// Contract
// - Two-fold mode supports complex bandwidth of 80% of input rate.
// - Four-fold mode: converter rate is four times the input rate.
// - Eight-fold mode: converter rate is eight times the input rate.
// - Four-fold via first and second stages gives 50% to 80% bandwidth.
// - Four-fold may bypass first stage, using second and third stages.
// - First stage mode 1 or 3 with premodulation shifts by half input rate.
// - Modes 2,2,1 in eight-fold centre output at input rate, translated by it.
// - Modes 1,1 with third bypassed: four-fold, centred at half rate, untranslated.
// - Each stage runs at twice the rate of the previous stage.
// - Carrier frequency is word over two to 32 times oscillator rate.
// - Usable bandwidth shrinks as centre moves off active stage centres.
// - New carrier word takes effect on 0-to-1 edge of update bit.
// - Oscillator runs at input rate, or twice it with first stage enabled.
`timescale 1ns/1ns
`default_nettype none

package ims_pkg;
	localparam int SAMPLE_W   = 16;
	localparam int CARRIER_W  = 32;
	localparam int PHASE_LUT_W = 3;
	localparam int TCNT_W     = 4;
	localparam int FACTOR_W   = 4;
	localparam int Q_SHIFT    = 15;
	// Stage mode code layout
	localparam int FIRST_SEL_W  = 2;
	localparam int LATER_SEL_W  = 6;
	localparam int FIRST_ODD_BIT = 0;
	localparam int FIRST_MOD_BIT = 1;
	localparam int LATER_MOD_BIT = 2;
	localparam int LATER_MODE_W  = 3;
	// Q15 carrier levels
	localparam logic signed [SAMPLE_W-1:0] Q_ONE  = 16'sh7fff;
	localparam logic signed [SAMPLE_W-1:0] Q_R    = 16'sh5a82;
	localparam logic signed [SAMPLE_W-1:0] Q_ZERO = 16'sh0000;
	localparam logic signed [SAMPLE_W-1:0] Q_NR   = 16'sha57e;
	localparam logic signed [SAMPLE_W-1:0] Q_NONE = 16'sh8001;
	localparam logic signed [SAMPLE_W-1:0] S_MAX  = 16'sh7fff;
	localparam logic signed [SAMPLE_W-1:0] S_MIN  = 16'sh8000;
	localparam logic [FACTOR_W-1:0] FACTOR_ONE = 4'h1;
	localparam logic [TCNT_W-1:0]   T_ONE      = 4'h1;

	function automatic logic [TCNT_W-1:0] low_mask(input logic [1:0] k);
		low_mask = (T_ONE << k) - T_ONE;
	endfunction

	function automatic logic signed [SAMPLE_W-1:0] sat16(input logic signed [32:0] v);
		logic signed [32:0] hi;
		logic signed [32:0] lo;
		hi = S_MAX;
		lo = S_MIN;
		if (v > hi)
			sat16 = S_MAX;
		else if (v < lo)
			sat16 = S_MIN;
		else
			sat16 = v[SAMPLE_W-1:0];
	endfunction

	// Negating full-scale negative would wrap, so clamp it
	function automatic logic signed [SAMPLE_W-1:0] neg_sat(input logic signed [SAMPLE_W-1:0] v);
		neg_sat = (v == S_MIN) ? S_MAX : -v;
	endfunction

	function automatic logic signed [SAMPLE_W-1:0] carrier_cos(input logic [PHASE_LUT_W-1:0] p);
		unique case (p)
			3'h0: carrier_cos = Q_ONE;
			3'h1: carrier_cos = Q_R;
			3'h2: carrier_cos = Q_ZERO;
			3'h3: carrier_cos = Q_NR;
			3'h4: carrier_cos = Q_NONE;
			3'h5: carrier_cos = Q_NR;
			3'h6: carrier_cos = Q_ZERO;
			3'h7: carrier_cos = Q_R;
		endcase
	endfunction

	function automatic logic signed [SAMPLE_W-1:0] carrier_sin(input logic [PHASE_LUT_W-1:0] p);
		carrier_sin = carrier_cos(p - 3'h2);
	endfunction
endpackage

module ims_carrier_nco #(
	parameter int WORD_W = ims_pkg::CARRIER_W
) (
	input  wire logic                                ref_clk_in,
	input  wire logic                                rst_n_in,
	input  wire logic [WORD_W-1:0]                   carrier_step_word_in,
	input  wire logic                                carrier_update_in,
	input  wire logic                                step_in,
	output logic      [WORD_W-1:0]                   active_word_out,
	output logic      [ims_pkg::PHASE_LUT_W-1:0]     phase_out
);
	logic              upd_q;
	logic [WORD_W-1:0] word_q;
	logic [WORD_W-1:0] acc_q;
	logic              upd_rise;

	assign upd_rise = carrier_update_in && !upd_q;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			upd_q <= 1'b0;
		else
			upd_q <= carrier_update_in;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			word_q <= '0;
		else if (upd_rise)
			word_q <= carrier_step_word_in;
	end

	// Phase accumulator modulo two to 32
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			acc_q <= '0;
		else if (step_in)
			acc_q <= acc_q + word_q;
	end

	assign active_word_out = word_q;
	assign phase_out       = acc_q[WORD_W-1 -: ims_pkg::PHASE_LUT_W];

	word_apply_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(carrier_update_in && !upd_q) |=> (word_q == $past(carrier_step_word_in)))
		else $error("carrier word not applied on update edge");
	word_hold_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		!(carrier_update_in && !upd_q) |=> $stable(word_q))
		else $error("carrier word changed without update edge");
	acc_idle_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
		(!step_in ##1 step_in) |=> (acc_q == $past(acc_q, 2) + $past(word_q)))
		else $error("accumulator moved off its step");
endmodule // ims_carrier_nco

`default_nettype wire

// *** ims_interp_mode_select.sv ***
`timescale 1ns/1ns
`default_nettype none

module ims_interp_mode_select (
	input  wire logic                                  ref_clk_in,
	input  wire logic                                  rst_n_in,
	input  wire logic [ims_pkg::FIRST_SEL_W-1:0]       first_stage_mode_sel_in,
	input  wire logic [ims_pkg::LATER_SEL_W-1:0]       second_stage_mode_sel_in,
	input  wire logic [ims_pkg::LATER_SEL_W-1:0]       third_stage_mode_sel_in,
	input  wire logic                                  first_stage_en_in,
	input  wire logic                                  second_stage_en_in,
	input  wire logic                                  third_stage_en_in,
	input  wire logic                                  premod_en_in,
	input  wire logic                                  carrier_en_in,
	input  wire logic [ims_pkg::CARRIER_W-1:0]         carrier_step_word_in,
	input  wire logic                                  carrier_update_in,
	input  wire logic signed [ims_pkg::SAMPLE_W-1:0]   in_i_in,
	input  wire logic signed [ims_pkg::SAMPLE_W-1:0]   in_q_in,
	input  wire logic                                  in_valid_in,
	output logic                                       in_ready_out,
	output logic signed [ims_pkg::SAMPLE_W-1:0]        out_i_out,
	output logic signed [ims_pkg::SAMPLE_W-1:0]        out_q_out,
	output logic                                       out_valid_out,
	output logic                                       underrun_out,
	output logic [ims_pkg::FACTOR_W-1:0]               interp_factor_out,
	output logic [ims_pkg::CARRIER_W-1:0]              active_word_out
);
	localparam int SW = ims_pkg::SAMPLE_W;

	logic [ims_pkg::TCNT_W-1:0] t_q;
	logic [ims_pkg::TCNT_W-1:0] tp_q;
	logic signed [SW-1:0]       x_i_q;
	logic signed [SW-1:0]       x_q_q;
	logic signed [SW-1:0]       out_i_q;
	logic signed [SW-1:0]       out_q_q;
	logic                       underrun_q;
	logic                       valid_q;
	logic [1:0]                 n_active;
	logic [1:0]                 after_first;
	logic [1:0]                 after_second;
	logic                       slot_start;
	logic                       take;
	logic                       nco_step;
	logic [ims_pkg::PHASE_LUT_W-1:0] phase;
	logic                       premod_act;
	logic                       first_mod;
	logic                       second_mod;
	logic                       third_mod;
	logic                       neg_w;
	logic                       premod_par;
	logic signed [SW-1:0]       car_c;
	logic signed [SW-1:0]       car_s;
	logic signed [SW-1:0]       mix_i;
	logic signed [SW-1:0]       mix_q;
	logic [18:0]                cfg_now;
	logic [18:0]                cfg_q;
	logic                       cfg_chg;

	// Checks in flight are void across a configuration change
	assign cfg_now = {first_stage_mode_sel_in, second_stage_mode_sel_in, third_stage_mode_sel_in,
		first_stage_en_in, second_stage_en_in, third_stage_en_in, premod_en_in, carrier_en_in};
	assign cfg_chg = cfg_now != cfg_q;

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			cfg_q <= '0;
		else
			cfg_q <= cfg_now;
	end

	assign first_mod  = first_stage_en_in && first_stage_mode_sel_in[ims_pkg::FIRST_MOD_BIT];
	assign second_mod = second_stage_en_in && second_stage_mode_sel_in[ims_pkg::LATER_MOD_BIT];
	assign third_mod  = third_stage_en_in && third_stage_mode_sel_in[ims_pkg::LATER_MOD_BIT];
	// Pass band follows mode only
	// Non-modulating modes only move the filter centre; responses live outside this block.

	assign premod_act = premod_en_in && first_stage_en_in &&
		first_stage_mode_sel_in[ims_pkg::FIRST_ODD_BIT];

	assign n_active     = 2'(first_stage_en_in) + 2'(second_stage_en_in) + 2'(third_stage_en_in);
	assign after_first  = 2'(second_stage_en_in) + 2'(third_stage_en_in);
	assign after_second = 2'(third_stage_en_in);

	assign interp_factor_out = ims_pkg::FACTOR_ONE << n_active;

	// One converter sample per clock; inputs are taken once per factor cycles
	assign slot_start   = (t_q & ims_pkg::low_mask(n_active)) == '0;
	assign in_ready_out = slot_start;
	assign take         = slot_start && in_valid_in;

	assign nco_step = (t_q & ims_pkg::low_mask(after_first)) == ims_pkg::low_mask(after_first);

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			t_q <= '0;
		else
			t_q <= t_q + ims_pkg::T_ONE;
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			tp_q <= '0;
		else
			tp_q <= t_q;
	end

	// Missing input at a slot sends silence rather than stalling the converter
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			x_i_q <= '0;
			x_q_q <= '0;
		end else if (slot_start) begin
			x_i_q <= in_valid_in ? in_i_in : '0;
			x_q_q <= in_valid_in ? in_q_in : '0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			underrun_q <= 1'b0;
		else
			underrun_q <= slot_start && !in_valid_in;
	end

	// Each stage signs at its own rate
	always_comb begin
		neg_w = 1'b0;
		if (premod_act)
			neg_w = neg_w ^ tp_q[n_active];
		if (first_mod)
			neg_w = neg_w ^ tp_q[after_first];
		if (second_mod)
			neg_w = neg_w ^ tp_q[after_second];
		if (third_mod)
			neg_w = neg_w ^ tp_q[0];
	end

	ims_carrier_nco #(
		.WORD_W (ims_pkg::CARRIER_W)
	) u_nco (
		.ref_clk_in           (ref_clk_in),
		.rst_n_in             (rst_n_in),
		.carrier_step_word_in (carrier_step_word_in),
		.carrier_update_in    (carrier_update_in),
		.step_in              (nco_step),
		.active_word_out      (active_word_out),
		.phase_out            (phase)
	);

	assign car_c = ims_pkg::carrier_cos(phase);
	assign car_s = ims_pkg::carrier_sin(phase);

	// Complex carrier mix
	// Coarse eight-point carrier keeps area low at the cost of spur level.
	always_comb begin
		logic signed [31:0] p_ic;
		logic signed [31:0] p_qs;
		logic signed [31:0] p_is;
		logic signed [31:0] p_qc;
		logic signed [32:0] s_i;
		logic signed [32:0] s_q;
		p_ic = x_i_q * car_c;
		p_qs = x_q_q * car_s;
		p_is = x_i_q * car_s;
		p_qc = x_q_q * car_c;
		// Concatenation is unsigned, so restore the sign before the arithmetic shift
		s_i = $signed({p_ic[31], p_ic} - {p_qs[31], p_qs}) >>> ims_pkg::Q_SHIFT;
		s_q = $signed({p_is[31], p_is} + {p_qc[31], p_qc}) >>> ims_pkg::Q_SHIFT;
		if (carrier_en_in) begin
			mix_i = ims_pkg::sat16(s_i);
			mix_q = ims_pkg::sat16(s_q);
		end else begin
			mix_i = x_i_q;
			mix_q = x_q_q;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_i_q <= '0;
			out_q_q <= '0;
		end else begin
			out_i_q <= neg_w ? ims_pkg::neg_sat(mix_i) : mix_i;
			out_q_q <= neg_w ? ims_pkg::neg_sat(mix_q) : mix_q;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			valid_q <= 1'b0;
		else
			valid_q <= 1'b1;
	end

	assign out_i_out     = out_i_q;
	assign out_q_out     = out_q_q;
	assign out_valid_out = valid_q;
	assign underrun_out  = underrun_q;

	// Helper for checks: input-rate parity at the taking cycle
	assign premod_par = t_q[n_active];

	rate_two_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in || cfg_chg)
		(in_ready_out && first_stage_en_in && !second_stage_en_in && !third_stage_en_in)
		|=> !in_ready_out ##1 in_ready_out)
		else $error("two-fold input spacing wrong");

	rate_four_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in || cfg_chg)
		(in_ready_out && interp_factor_out == 4'h4) |=> !in_ready_out[*3] ##1 in_ready_out)
		else $error("four-fold input spacing wrong");

	rate_eight_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in || cfg_chg)
		(in_ready_out && interp_factor_out == 4'h8) |=> !in_ready_out[*7] ##1 in_ready_out)
		else $error("eight-fold input spacing wrong");

	nco_double_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in || cfg_chg)
		(in_ready_out && first_stage_en_in && second_stage_en_in && !third_stage_en_in)
		|-> ##1 nco_step ##1 !nco_step ##1 nco_step)
		else $error("oscillator not at twice input rate");

	nco_single_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in || cfg_chg)
		(in_ready_out && !first_stage_en_in && second_stage_en_in && third_stage_en_in)
		|-> !nco_step[*3] ##1 nco_step)
		else $error("oscillator not at input rate when first stage bypassed");

	premod_sign_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in || cfg_chg)
		(take && premod_act && !first_mod && !second_mod && !third_mod && !carrier_en_in &&
			in_i_in != ims_pkg::S_MIN)
		|-> ##2 (out_i_out == ($past(premod_par, 2) ? -$past(in_i_in, 2) : $past(in_i_in, 2))))
		else $error("premodulation sign wrong");

	shift_fin_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in || cfg_chg)
		(take && first_stage_en_in && second_stage_en_in && third_stage_en_in &&
			first_stage_mode_sel_in == 2'h2 && second_stage_mode_sel_in == 6'h12 &&
			third_stage_mode_sel_in == 6'h09 && !premod_en_in && !carrier_en_in &&
			in_i_in != ims_pkg::S_MIN)
		|-> ##2 (out_i_out == $past(in_i_in, 2)) ##4 (out_i_out == -$past(in_i_in, 6)))
		else $error("input-rate translation wrong");

	no_shift_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in || cfg_chg)
		(take && first_stage_en_in && second_stage_en_in && !third_stage_en_in &&
			first_stage_mode_sel_in == 2'h1 && second_stage_mode_sel_in == 6'h09 &&
			!premod_en_in && !carrier_en_in)
		|-> ##2 (out_i_out == $past(in_i_in, 2)) ##1 (out_i_out == $past(in_i_in, 3)))
		else $error("untranslated mode altered samples");
endmodule // ims_interp_mode_select

`default_nettype wire

// *** interpolation_mode_select_test.sv ***
`timescale 1ns/1ns
`default_nettype none

module interpolation_mode_select_test;
	logic               ref_clk_in = 1'b0;
	logic               rst_n_in = 1'b0;
	logic [1:0]         f_sel = 2'h0;
	logic [5:0]         s2_sel = 6'h00;
	logic [5:0]         s3_sel = 6'h00;
	logic               e1 = 1'b0, e2 = 1'b0, e3 = 1'b0, pm = 1'b0, ce = 1'b0;
	logic               upd = 1'b0;
	logic               vld = 1'b1;
	logic [31:0]        word = 32'h00000000;
	logic signed [15:0] di = 16'sh1234;
	logic signed [15:0] dq = 16'sh0000;
	logic               rdy, ov, ur;
	logic signed [15:0] oi, oq;
	logic [3:0]         fac;
	logic [31:0]        aw;
	logic signed [15:0] s [0:7];
	int                 err_total = 0;
	int                 check_count = 0;
	int                 cyc = 0;

	ims_interp_mode_select DUT (
		.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
		.first_stage_mode_sel_in(f_sel), .second_stage_mode_sel_in(s2_sel),
		.third_stage_mode_sel_in(s3_sel), .first_stage_en_in(e1),
		.second_stage_en_in(e2), .third_stage_en_in(e3), .premod_en_in(pm),
		.carrier_en_in(ce), .carrier_step_word_in(word), .carrier_update_in(upd),
		.in_i_in(di), .in_q_in(dq), .in_valid_in(vld), .in_ready_out(rdy),
		.out_i_out(oi), .out_q_out(oq), .out_valid_out(ov), .underrun_out(ur),
		.interp_factor_out(fac), .active_word_out(aw)
	);

	initial begin
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	// Whole run needs about 380 cycles
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Config then settle long enough for a fresh slot
	task automatic cfg(input logic [1:0] f, input logic [5:0] m2, input logic [5:0] m3,
			input logic [4:0] en);
		@(posedge ref_clk_in);
		f_sel <= f;
		s2_sel <= m2;
		s3_sel <= m3;
		{e1, e2, e3, pm, ce} <= en;
		repeat (20) @(posedge ref_clk_in);
		@(negedge ref_clk_in);
	endtask

	task automatic grab();
		for (int k = 0; k < 8; k++) begin
			s[k] = oi;
			@(negedge ref_clk_in);
		end
	endtask

	task automatic ready_count(output int n);
		n = 0;
		for (int k = 0; k < 16; k++) begin
			if (rdy === 1'b1)
				n++;
			@(negedge ref_clk_in);
		end
	endtask

	logic [2:0] ens [0:4] = '{3'b000, 3'b100, 3'b110, 3'b011, 3'b111};
	logic [3:0] facs [0:4] = '{4'h1, 4'h2, 4'h4, 4'h4, 4'h8};
	int n;
	int zeros;
	logic signed [15:0] sum;
	logic seen;

	initial begin
		repeat (3) @(negedge ref_clk_in);
		chk(ov, 0);
		chk(rdy, 1);
		rst_n_in = 1'b1;
		@(negedge ref_clk_in);
		chk(ov, 1);
		$display("test reset done");
		for (int c = 0; c < 5; c++) begin
			cfg(2'h0, 6'h00, 6'h00, {ens[c], 2'b00});
			chk(fac, facs[c]);
			ready_count(n);
			chk(n, 16 / facs[c]);
		end
		$display("test factors done");
		cfg(2'h1, 6'h09, 6'h00, 5'b11000);
		grab();
		for (int k = 0; k < 8; k++)
			chk(s[k], 16'sh1234);
		cfg(2'h2, 6'h12, 6'h09, 5'b11100);
		grab();
		for (int k = 0; k < 4; k++) begin
			chk(s[k] == 16'sh1234 || s[k] == -16'sh1234, 1);
			chk(s[k + 4], -s[k]);
		end
		$display("test stage modes done");
		cfg(2'h1, 6'h00, 6'h00, 5'b10010);
		grab();
		for (int k = 0; k < 6; k++)
			chk(s[k + 2], -s[k]);
		cfg(2'h0, 6'h00, 6'h00, 5'b10010);
		grab();
		for (int k = 0; k < 8; k++)
			chk(s[k], 16'sh1234);
		$display("test premod done");
		@(posedge ref_clk_in);
		word <= 32'h40000000;
		@(negedge ref_clk_in);
		chk(aw, 32'h0);
		@(posedge ref_clk_in);
		upd <= 1'b1;
		@(negedge ref_clk_in);
		chk(aw, 32'h0);
		@(negedge ref_clk_in);
		chk(aw, 32'h40000000);
		@(posedge ref_clk_in);
		word <= 32'h12345678;
		repeat (3) @(negedge ref_clk_in);
		chk(aw, 32'h40000000);
		$display("test update done");
		// Quarter-turn steps at input rate give levels 3fff, 0, c000, 0
		di <= 16'sh4000;
		cfg(2'h0, 6'h00, 6'h00, 5'b00001);
		grab();
		sum = 0;
		zeros = 0;
		for (int k = 0; k < 4; k++) begin
			sum += s[k];
			if (s[k] === 16'sh0000)
				zeros++;
		end
		chk(sum, -16'sh1);
		chk(zeros, 2);
		$display("test carrier done");
		cfg(2'h0, 6'h00, 6'h00, 5'b10000);
		@(posedge ref_clk_in);
		vld <= 1'b0;
		repeat (4) @(negedge ref_clk_in);
		seen = 1'b0;
		for (int k = 0; k < 8; k++) begin
			if (ur === 1'b1)
				seen = 1'b1;
			chk(oi, 16'sh0000);
			chk(oq, 16'sh0000);
			@(negedge ref_clk_in);
		end
		chk(seen, 1);
		$display("test underrun done");
		tally_and_finish();
	end
endmodule // interpolation_mode_select_test

`default_nettype wire
